// file: hw/flash_resume_powerdown_id_cmds.sv
`timescale 1ns/1ps
module flash_resume_powerdown_id_cmds
(
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       select_n,
   input  wire logic       link_clk,
   input  wire logic [3:0] io_in,
   output logic      [3:0] io_out,
   output logic      [3:0] io_oe,
   input  wire logic       op_start,
   input  wire logic       op_done,
   input  wire logic       power_lost,
   output logic            busy,
   output logic            suspend_flag,
   output logic            powered_down,
   output logic            op_suspend,
   output logic            op_resume
);
   import flash_cmd_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisation and edge finding
   // ------------------------------------------------------------
   logic [5:0] pins_sync;
   logic       cs_n_s;
   logic       sck_s;
   logic [3:0] io_s;
   logic       sck_prev;
   logic       cs_prev;
   logic       sck_rise;
   logic       sck_fall;
   logic       cs_rise;

   link_sync #(.WIDTH(6)) u_sync
   (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .async_in ({select_n, link_clk, io_in}),
      .sync_out (pins_sync)
   );

   assign cs_n_s = pins_sync[5];
   assign sck_s  = pins_sync[4];
   assign io_s   = pins_sync[3:0];

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sck_prev <= 1'b0;
         cs_prev  <= 1'b1;
      end
      else
      begin
         sck_prev <= sck_s;
         cs_prev  <= cs_n_s;
      end
   end

   assign sck_rise = !cs_n_s && sck_s && !sck_prev;
   assign sck_fall = !cs_n_s && !sck_s && sck_prev;
   assign cs_rise  = cs_n_s && !cs_prev;

   // ------------------------------------------------------------
   // Shift-in of opcode and address
   // ------------------------------------------------------------
   logic [6:0]   clk_count;
   logic [7:0]   opcode;
   logic [23:0]  addr;
   io_width_type in_width;

   function automatic io_width_type width_of(input logic [7:0] op);
      case (op)
         OP_MFR_DEV_2: width_of = WIDTH_2;
         OP_MFR_DEV_4: width_of = WIDTH_4;
         default:      width_of = WIDTH_1;
      endcase
   endfunction : width_of

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         clk_count <= '0;
         opcode    <= '0;
         addr      <= '0;
      end
      else if (cs_n_s)
      begin
         clk_count <= '0;
      end
      else if (sck_rise)
      begin
         if (clk_count != 7'h7F)
            clk_count <= clk_count + 7'd1;
         if (clk_count < OPCODE_CLKS)
            opcode <= {opcode[6:0], io_s[0]};
         else if (in_width == WIDTH_2 && clk_count < 7'd20)
            addr <= {addr[21:0], io_s[1:0]};
         else if (in_width == WIDTH_4 && clk_count < QUAD_ADDR_END)
            addr <= {addr[19:0], io_s};
         else if (in_width == WIDTH_1 && clk_count < SINGLE_ID_CLKS)
            addr <= {addr[22:0], io_s[0]};
      end
   end

   assign in_width = (clk_count >= OPCODE_CLKS) ? width_of(opcode) : WIDTH_1;

   // ------------------------------------------------------------
   // Power-down state
   // ------------------------------------------------------------
   logic        pd_pending;
   logic [15:0] pd_timer;
   logic        releasing;
   logic [15:0] rel_timer;
   logic        blocked;
   logic        eight_exact;

   assign eight_exact = cs_rise && clk_count == OPCODE_CLKS;
   assign blocked     = releasing;

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         powered_down <= 1'b0;
         pd_pending   <= 1'b0;
         pd_timer     <= '0;
         releasing    <= 1'b0;
         rel_timer    <= '0;
      end
      else
      begin
         if (eight_exact && !powered_down && !blocked && opcode == OP_POWERDOWN)
         begin
            pd_pending <= 1'b1;
            pd_timer   <= PD_ENTRY_CYCLES;
         end
         else if (pd_pending)
         begin
            if (pd_timer == '0)
            begin
               pd_pending   <= 1'b0;
               powered_down <= 1'b1;
            end
            else
               pd_timer <= pd_timer - 16'd1;
         end
         if (powered_down && cs_rise && clk_count >= OPCODE_CLKS
             && opcode == OP_RELEASE_ID)
         begin
            releasing <= 1'b1;
            rel_timer <= (clk_count == OPCODE_CLKS) ? RELEASE_CYCLES
                                                    : RELEASE_ID_CYCLES;
         end
         else if (releasing)
         begin
            if (rel_timer == '0)
            begin
               releasing    <= 1'b0;
               powered_down <= 1'b0;
            end
            else
               rel_timer <= rel_timer - 16'd1;
         end
      end
   end

   // ------------------------------------------------------------
   // Suspend and resume
   // ------------------------------------------------------------
   logic       normal;
   logic       resume_go;
   logic       suspend_go;
   logic       busy_wait;
   logic [3:0] busy_timer;

   assign normal     = !powered_down && !releasing && !pd_pending;
   assign resume_go  = eight_exact && normal && opcode == OP_RESUME
                       && suspend_flag && !busy && !power_lost;
   assign suspend_go = eight_exact && normal && opcode == OP_SUSPEND
                       && busy && !suspend_flag && !busy_wait;

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         busy         <= 1'b0;
         suspend_flag <= 1'b0;
         busy_wait    <= 1'b0;
         busy_timer   <= '0;
         op_suspend   <= 1'b0;
         op_resume    <= 1'b0;
      end
      else
      begin
         op_suspend <= suspend_go;
         op_resume  <= resume_go;
         if (power_lost)
         begin
            suspend_flag <= 1'b0;
            busy         <= 1'b0;
            busy_wait    <= 1'b0;
         end
         else if (resume_go)
         begin
            suspend_flag <= 1'b0;
            busy_wait    <= 1'b1;
            busy_timer   <= BUSY_SET_CYCLES;
         end
         else if (busy_wait)
         begin
            if (busy_timer == '0)
            begin
               busy      <= 1'b1;
               busy_wait <= 1'b0;
            end
            else
               busy_timer <= busy_timer - 4'd1;
         end
         else if (suspend_go)
         begin
            suspend_flag <= 1'b1;
            busy         <= 1'b0;
         end
         else if (op_start)
            busy <= 1'b1;
         else if (op_done && !suspend_flag)
            busy <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Identification output
   // ------------------------------------------------------------
   logic [63:0] out_shift;
   logic [6:0]  out_bits;
   logic        out_active;
   logic        id_start;
   logic        id_repeat;
   logic [6:0]  start_clks;

   function automatic logic [63:0] id_pattern(input logic [7:0]  op,
                                              input logic [23:0] a);
      logic [15:0] pair;
      pair = (a == ADDR_DEV_FIRST) ? {DEV_ID, MFR_ID} : {MFR_ID, DEV_ID};
      case (op)
         OP_RELEASE_ID: id_pattern = {8{DEV_ID}};
         OP_UNIQUE_ID:  id_pattern = UNIQUE_ID;
         default:       id_pattern = {4{pair}};
      endcase
   endfunction : id_pattern

   always_comb
   begin
      case (opcode)
         OP_RELEASE_ID: start_clks = REL_ID_CLKS;
         OP_MFR_DEV_1:  start_clks = SINGLE_ID_CLKS;
         OP_MFR_DEV_2:  start_clks = DUAL_ID_CLKS;
         OP_MFR_DEV_4:  start_clks = QUAD_ID_CLKS;
         OP_UNIQUE_ID:  start_clks = UNIQUE_CLKS;
         default:       start_clks = 7'h7F;
      endcase
   end

   assign id_start  = sck_fall && !out_active && clk_count == start_clks
                      && !busy && !releasing
                      && (!powered_down || opcode == OP_RELEASE_ID);
   assign id_repeat = opcode != OP_UNIQUE_ID;

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         out_shift  <= '0;
         out_bits   <= '0;
         out_active <= 1'b0;
         io_out     <= '0;
         io_oe      <= '0;
      end
      else if (cs_n_s)
      begin
         out_active <= 1'b0;
         io_oe      <= '0;
      end
      else if (id_start || (out_active && sck_fall))
      begin
         logic [63:0] src;
         logic [6:0]  step;
         src = id_start ? id_pattern(opcode, addr) : out_shift;
         step = (width_of(opcode) == WIDTH_4) ? 7'd4
              : (width_of(opcode) == WIDTH_2) ? 7'd2 : 7'd1;
         out_active <= 1'b1;
         case (width_of(opcode))
            WIDTH_4:
            begin
               io_out <= src[63:60];
               io_oe  <= 4'hF;
               out_shift <= id_repeat ? {src[59:0], src[63:60]} : {src[59:0], 4'h0};
            end
            WIDTH_2:
            begin
               io_out <= {2'b00, src[63:62]};
               io_oe  <= 4'h3;
               out_shift <= {src[61:0], src[63:62]};
            end
            default:
            begin
               io_out <= {2'b00, src[63], 1'b0};
               io_oe  <= 4'h2;
               out_shift <= id_repeat ? {src[62:0], src[63]} : {src[62:0], 1'b0};
            end
         endcase
         out_bits <= id_start ? step : out_bits + step;
      end
   end

endmodule : flash_resume_powerdown_id_cmds

// file: hw/flash_cmd_pkg.sv
package flash_cmd_pkg;

   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_RESUME     = 8'h7A;
   localparam logic [7:0] OP_SUSPEND    = 8'h75;
   localparam logic [7:0] OP_POWERDOWN  = 8'hB9;
   localparam logic [7:0] OP_RELEASE_ID = 8'hAB;
   localparam logic [7:0] OP_MFR_DEV_1  = 8'h90;
   localparam logic [7:0] OP_MFR_DEV_2  = 8'h92;
   localparam logic [7:0] OP_MFR_DEV_4  = 8'h94;
   localparam logic [7:0] OP_UNIQUE_ID  = 8'h4B;

   // ------------------------------------------------------------
   // Identification values (arbitrary, neutral)
   // ------------------------------------------------------------
   localparam logic [7:0]  MFR_ID    = 8'h5A;
   localparam logic [7:0]  DEV_ID    = 8'h16;
   localparam logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF;

   // ------------------------------------------------------------
   // Frame layout in link clocks (rising edges) and address values
   // ------------------------------------------------------------
   localparam logic [23:0] ADDR_DEV_FIRST = 24'h000001;
   localparam logic [6:0]  OPCODE_CLKS    = 7'd8;
   localparam logic [6:0]  REL_ID_CLKS    = 7'd32;  // Opcode + 3 dummy bytes
   localparam logic [6:0]  SINGLE_ID_CLKS = 7'd32;  // Opcode + 24-bit address
   localparam logic [6:0]  DUAL_ID_CLKS   = 7'd24;  // Opcode + 16 clocks addr/mode
   localparam logic [6:0]  QUAD_ID_CLKS   = 7'd20;  // Opcode + 8 addr/mode + 4 dummy
   localparam logic [6:0]  QUAD_ADDR_END  = 7'd14;
   localparam logic [6:0]  UNIQUE_CLKS    = 7'd40;  // Opcode + 4 dummy bytes

   // ------------------------------------------------------------
   // Timing at 20 MHz
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 50;
   localparam int BUSY_SET_NS    = 200;
   // Pin synchronisation already uses most of the busy-set budget
   localparam logic [3:0] BUSY_SET_CYCLES = 4'h0;
   localparam int PD_ENTRY_NS    = 3000;
   localparam logic [15:0] PD_ENTRY_CYCLES = 16'(PD_ENTRY_NS / CLK_PERIOD_NS);
   localparam int RELEASE_NS     = 3000;
   localparam int RELEASE_ID_NS  = 3600;
   localparam logic [15:0] RELEASE_CYCLES =
      16'((RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] RELEASE_ID_CYCLES =
      16'((RELEASE_ID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      WIDTH_1 = 2'b00,
      WIDTH_2 = 2'b01,
      WIDTH_4 = 2'b10
   } io_width_type;

endpackage : flash_cmd_pkg

// file: hw/link_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for the link pins
module link_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         stage1   <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule : link_sync

// file: test/flash_cmds_chk.sv
`timescale 1ns/1ps
module flash_cmds_chk
(
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic       select_n,
   input wire logic       link_clk,
   input wire logic [3:0] io_in,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe,
   input wire logic       op_start,
   input wire logic       op_done,
   input wire logic       power_lost,
   input wire logic       busy,
   input wire logic       suspend_flag,
   input wire logic       powered_down,
   input wire logic       op_suspend,
   input wire logic       op_resume
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   reset_state_a: assert property ($past(sys_rst) |-> !powered_down && !busy && !suspend_flag)
      else $error("Flags set after reset");
   resume_gate_a: assert property (op_resume |-> $past(suspend_flag) && !$past(busy))
      else $error("Resume taken in wrong state");
   resume_clear_a: assert property (op_resume |-> ##[0:1] !suspend_flag)
      else $error("Suspend flag kept after resume");
   resume_busy_a: assert property (op_resume |-> ##[0:4] busy)
      else $error("Busy late after resume");
   suspend_gate_a: assert property (op_suspend |-> $past(busy) && !$past(suspend_flag))
      else $error("Suspend taken in wrong state");
   suspend_effect_a: assert property (op_suspend |-> ##[0:1] (suspend_flag && !busy))
      else $error("Suspend did not take effect");
   power_loss_a: assert property (power_lost |=> !suspend_flag && !busy)
      else $error("Power loss left state set");
   oe_idle_a: assert property (select_n [*6] |-> io_oe == 4'h0)
      else $error("Pins driven while deselected");
   oe_busy_a: assert property ($rose(|io_oe) |-> !busy)
      else $error("Output started while busy");
   oe_width_a: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
      else $error("Bad output enable pattern");
   cover property (op_resume);
   cover property (op_suspend);
   cover property ($rose(powered_down));
   cover property (io_oe == 4'hF);
endmodule : flash_cmds_chk

bind flash_resume_powerdown_id_cmds flash_cmds_chk chk (.clk_sys, .sys_rst, .select_n,
   .link_clk, .io_in, .io_out, .io_oe, .op_start, .op_done, .power_lost, .busy,
   .suspend_flag, .powered_down, .op_suspend, .op_resume);

// file: test/host_spi_model.sv
`timescale 1ns/1ps
module host_spi_model
(
   input  wire logic       clk_sys,
   input  wire logic [3:0] io_pin,
   output logic            select_n,
   output logic            link_clk,
   output logic      [3:0] host_io
);
   initial
   begin
      select_n = 1'b1;
      link_clk = 1'b0;
      host_io  = 4'h0;
   end
   // Link clock idles low; released lines are inverted so no stale value survives
   task automatic frame(input logic [7:0] op, input logic [63:0] tx, input int n_tx,
                        input int w_tx, input int n_rx, input int w_rx,
                        output logic [63:0] rx);
      logic [71:0] sh;
      logic [3:0]  m;
      int          w;
      sh = {op, tx};
      rx = 64'h0;
      @(posedge clk_sys);
      select_n <= 1'b0;
      for (int i = 0; i < 8 + n_tx + n_rx; i++)
      begin
         w = (i < 8) ? 1 : (i < 8 + n_tx) ? w_tx : 0;
         m = 4'((1 << w) - 1);
         host_io <= ((sh[71:68] >> (4 - w)) & m) | (~host_io & ~m);
         sh = sh << w;
         repeat (4) @(posedge clk_sys);
         link_clk <= 1'b1;
         repeat (4) @(posedge clk_sys);
         if (i >= 8 + n_tx)
            rx = (rx << w_rx) | 64'(w_rx == 1 ? 4'(io_pin[1]) : io_pin & 4'((1 << w_rx) - 1));
         link_clk <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      select_n <= 1'b1;
      host_io  <= ~host_io;
      repeat (8) @(posedge clk_sys);
   endtask : frame
endmodule : host_spi_model

// file: test/flash_resume_powerdown_id_cmds_tb.sv
`timescale 1ns/1ps
module flash_resume_powerdown_id_cmds_tb;
   import flash_cmd_pkg::*;
   typedef struct {
      logic [7:0]  op;
      logic [63:0] tx;
      int          n_tx;
      int          w_tx;
      int          n_rx;
      int          w_rx;
      logic [63:0] exp;
   } row_type;
   logic        clk_sys = 1'b0;
   logic        sys_rst, op_start, op_done, power_lost, oe_seen;
   logic        select_n, link_clk, busy, suspend_flag, powered_down, op_suspend, op_resume;
   logic [3:0]  host_io, io_out, io_oe;
   wire  [3:0]  io_in;
   logic [2:0]  core_ev, flags;
   logic [63:0] rx;
   int          n_fail, comparisons, n_res;
   row_type     rows [6];
   assign io_in = (io_oe & io_out) | (~io_oe & host_io);
   assign flags = {powered_down, suspend_flag, busy};
   assign {power_lost, op_done, op_start} = core_ev;
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      if (io_oe !== 4'h0)
         oe_seen <= 1'b1;
      if (op_resume === 1'b1)
         n_res <= n_res + 1;
   end
   host_spi_model host (.clk_sys, .io_pin(io_in), .select_n, .link_clk, .host_io);
   flash_resume_powerdown_id_cmds dut (.clk_sys, .sys_rst, .select_n, .link_clk, .io_in,
      .io_out, .io_oe, .op_start, .op_done, .power_lost, .busy, .suspend_flag,
      .powered_down, .op_suspend, .op_resume);
   task results;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results
   task check_data(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check_data
   task check_bit(input logic got, input logic exp);
      check_data(64'(got), 64'(exp));
   endtask : check_bit
   task wait_for(input int k, input logic v);
      int i;
      for (i = 0; i < 300 && flags[k] !== v; i++)
         @(posedge clk_sys);
      check_bit(flags[k], v);
      if (i == 300)
         results();
   endtask : wait_for
   task cmd(input logic [7:0] op);
      host.frame(op, 64'h0, 0, 1, 0, 1, rx);
   endtask : cmd
   task strobe(input logic [2:0] e);
      core_ev <= e;
      @(posedge clk_sys);
      core_ev <= 3'b000;
   endtask : strobe
   initial
   begin
      sys_rst = 1'b1;
      core_ev = 3'b000;
      oe_seen = 1'b0;
      rows[0] = '{OP_MFR_DEV_1, 64'h0, 24, 1, 32, 1, {32'h0, MFR_ID, DEV_ID, MFR_ID, DEV_ID}};
      rows[1] = '{OP_MFR_DEV_1, {ADDR_DEV_FIRST, 40'h0}, 24, 1, 32, 1,
                  {32'h0, DEV_ID, MFR_ID, DEV_ID, MFR_ID}};
      rows[2] = '{OP_MFR_DEV_2, {24'h0, 8'hF0, 32'h0}, 16, 2, 16, 2,
                  {32'h0, MFR_ID, DEV_ID, MFR_ID, DEV_ID}};
      rows[3] = '{OP_MFR_DEV_4, {ADDR_DEV_FIRST, 8'hF0, 32'h0}, 12, 4, 8, 4,
                  {32'h0, DEV_ID, MFR_ID, DEV_ID, MFR_ID}};
      rows[4] = '{OP_RELEASE_ID, 64'h0, 24, 1, 16, 1, {48'h0, DEV_ID, DEV_ID}};
      rows[5] = '{OP_UNIQUE_ID, 64'h0, 32, 1, 64, 1, UNIQUE_ID};
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      foreach (rows[i])
      begin
         host.frame(rows[i].op, rows[i].tx, rows[i].n_tx, rows[i].w_tx, rows[i].n_rx,
                    rows[i].w_rx, rx);
         check_data(rx, rows[i].exp);
      end
      $display("Test id_reads done");
      strobe(3'b001);
      wait_for(0, 1'b1);
      cmd(OP_SUSPEND);
      wait_for(1, 1'b1);
      @(posedge clk_sys);
      check_bit(busy, 1'b0);
      cmd(OP_RESUME);
      wait_for(0, 1'b1);
      check_bit(suspend_flag, 1'b0);
      cmd(OP_RESUME);
      check_data(64'(n_res), 64'h1);
      oe_seen = 1'b0;
      host.frame(OP_RELEASE_ID, 64'h0, 24, 1, 16, 1, rx);
      check_bit(oe_seen, 1'b0);
      strobe(3'b010);
      wait_for(0, 1'b0);
      $display("Test suspend_resume done");
      repeat (20) @(posedge clk_sys);
      strobe(3'b001);
      cmd(OP_SUSPEND);
      wait_for(1, 1'b1);
      strobe(3'b100);
      cmd(OP_RESUME);
      check_data(64'(n_res), 64'h1);
      check_bit(busy, 1'b0);
      $display("Test power_loss done");
      host.frame(OP_POWERDOWN, 64'h0, 1, 1, 0, 1, rx);
      repeat (80) @(posedge clk_sys);
      check_bit(powered_down, 1'b0);
      cmd(OP_POWERDOWN);
      wait_for(2, 1'b1);
      oe_seen = 1'b0;
      host.frame(OP_MFR_DEV_1, 64'h0, 24, 1, 32, 1, rx);
      check_bit(oe_seen, 1'b0);
      cmd(OP_RELEASE_ID);
      repeat (RELEASE_CYCLES) @(posedge clk_sys);
      check_bit(powered_down, 1'b0);
      host.frame(rows[0].op, rows[0].tx, 24, 1, 32, 1, rx);
      check_data(rx, rows[0].exp);
      $display("Test power_down done");
      cmd(OP_POWERDOWN);
      wait_for(2, 1'b1);
      sys_rst <= 1'b1;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      check_bit(powered_down, 1'b0);
      $display("Test reset done");
      results();
   end
endmodule : flash_resume_powerdown_id_cmds_tb
